// [src/rsclk_top.sv]
// Radio and system clock control block with its APB register slave.
`timescale 1ns/1ps

// Summary of operation
// RL1: Radio clock bit 7 enables the radio core clock; off after reset.
// RL2: Radio clock bit 6 holds low-power radio timer in reset; set after reset.
// RL3: Bits 5:4 divide the radio core clock by 1, 2, 4 or 8.
// RL4: Software keeps the radio core clock between 8 MHz and the CPU clock.
// RL5: Radio clock bit 3 enables the RF control unit clock; off after reset.
// RL6: Bits 1:0 divide the RF control unit clock by 1, 2, 4 or 8.
// RL7: Software programs the RF control unit clock to exactly 8 MHz.
// RL8: Status bit 7 reads 1 while the fast crystal runs the system; resets 1.
// RL9: Status bit 6 reads 1 while the fast RC oscillator runs the system.
// RL10: Status bit 5 reads 1 while a slow 32 kHz source runs the system.
// RL11: Bit 3 bypasses the crystal clock glitch filter; filter active after reset.
// RL12: Bit 2 stops the fast crystal at once and keeps it off while set.
// RL13: Software never stops the crystal while the system runs on it.
// RL14: Software waits for crystal settled or trim done before selecting it.
// RL15: Source select: 0 fast crystal, 1 fast RC, 2 or 3 slow clock.
// RL16: Power bits 11:8 keep four retention RAM macros retained when set.
// RL17: Power bit 7 forces the DC-DC converter to boost at next wakeup.
// RL18: Power bit 6 forces the DC-DC converter to buck at next wakeup.
// RL19: Boost forcing wins over buck forcing when both are set.
// RL20: After a one is written to either force bit, both force bits ignore further writes.
// RL21: Crystal settled reads 1 after more than 2 ms of crystal running.
// RL22: Divider and source changes never truncate or glitch a clock.
module rsclk_top
    import rsclk_pkg::*;
#(
    parameter int SETTLE_CYCLES = XTAL_SETTLE_CYCLES
) (
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [31:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic fast_rc_osc_ready_in,
    input wire logic slow_clock_ready_in,
    output logic radio_core_clk_tick_out,
    output logic rf_ctrl_unit_clk_tick_out,
    output logic lowpower_radio_timer_rst_out,
    output logic glitch_filter_bypass_out,
    output logic fast_crystal_osc_en_out,
    output logic fast_crystal_settled_out,
    output logic [1:0] sysclk_source_sel_out,
    output logic on_fast_crystal_out,
    output logic on_fast_rc_osc_out,
    output logic on_slow_clock_out,
    output logic [3:0] retention_keep_out,
    output logic dcdc_force_boost_out,
    output logic dcdc_force_buck_out
);
    if (SETTLE_CYCLES < 1) begin : g_bad_settle
        $error("SETTLE_CYCLES must be at least one");
    end

    function automatic logic [DIV_CNT_W-1:0] div_last(input logic [1:0] code);
        div_last = DIV_CNT_W'((4'h1 << code) - 4'h1);
    endfunction

    function automatic logic hit(input logic [31:0] addr, input logic [31:0] idx);
        hit = (addr[IDX_DEC_W+1:2] == idx[IDX_DEC_W-1:0]);
    endfunction

    // APB decode; no wait states, read data captured in the setup phase.
    logic wr_en, setup, mapped;
    logic sel_radio, sel_sys, sel_pmu;
    assign sel_radio = hit(paddr_in, RADIO_CLK_IDX);
    assign sel_sys = hit(paddr_in, SYS_CLK_IDX);
    assign sel_pmu = hit(paddr_in, PMU_CTRL_IDX);
    assign mapped = sel_radio | sel_sys | sel_pmu;
    assign setup = psel_in & ~penable_in;
    assign wr_en = psel_in & penable_in & pwrite_in & mapped;
    assign pready_out = 1'b1;
    assign pslverr_out = psel_in & penable_in & ~mapped;

    // Pins from the oscillators are in another domain and are synchronised.
    logic [1:0] rc_rdy_q, slow_rdy_q;
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            rc_rdy_q <= 2'h0;
            slow_rdy_q <= 2'h0;
        end else begin
            rc_rdy_q <= {rc_rdy_q[0], fast_rc_osc_ready_in};
            slow_rdy_q <= {slow_rdy_q[0], slow_clock_ready_in};
        end
    end

    // Register group.
    logic [7:0] radio_q, radio_d;
    logic flt_byp_q, flt_byp_d;
    logic xtal_off_q, xtal_off_d;
    logic [1:0] src_sel_q, src_sel_d;
    logic [3:0] ret_q, ret_d;
    logic boost_q, boost_d;
    logic buck_q, buck_d;
    logic force_lock_q, force_lock_d;
    logic [7:0] wlo, whi;

    always_comb begin
        wlo = pwdata_in[7:0];
        whi = pwdata_in[15:8];
        radio_d = radio_q;
        flt_byp_d = flt_byp_q;
        xtal_off_d = xtal_off_q;
        src_sel_d = src_sel_q;
        ret_d = ret_q;
        boost_d = boost_q;
        buck_d = buck_q;
        force_lock_d = force_lock_q;
        if (wr_en && pstrb_in[0] && sel_radio) begin
            radio_d = wlo & RC_WMASK; // RL1 RL2 RL3 RL5 RL6
        end
        if (wr_en && pstrb_in[0] && sel_sys) begin
            flt_byp_d = wlo[SC_FLT_BYP_BIT]; // RL11
            xtal_off_d = wlo[SC_XTAL_OFF_BIT]; // RL12
            src_sel_d = wlo[SC_SEL_LSB+:2]; // RL15
        end
        if (wr_en && pstrb_in[1] && sel_pmu) begin
            ret_d = whi[PM_RET_LSB-8+:4]; // RL16
        end
        // Locking only on a written one lets software touch retention bits freely before forcing.
        if (wr_en && pstrb_in[0] && sel_pmu && !force_lock_q) begin
            boost_d = wlo[PM_BOOST_BIT]; // RL17 RL20
            buck_d = wlo[PM_BUCK_BIT]; // RL18 RL20
            force_lock_d = wlo[PM_BOOST_BIT] | wlo[PM_BUCK_BIT]; // RL20
        end
    end

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            radio_q <= RC_RESET;
            flt_byp_q <= 1'b0;
            xtal_off_q <= 1'b0;
            src_sel_q <= SC_SEL_RESET;
            ret_q <= PM_RET_RESET;
            boost_q <= 1'b0;
            buck_q <= 1'b0;
            force_lock_q <= 1'b0;
        end else begin
            radio_q <= radio_d;
            flt_byp_q <= flt_byp_d;
            xtal_off_q <= xtal_off_d;
            src_sel_q <= src_sel_d;
            ret_q <= ret_d;
            boost_q <= boost_d;
            buck_q <= buck_d;
            force_lock_q <= force_lock_d;
        end
    end

    // Crystal settle counter restarts whenever the crystal is stopped.
    logic [31:0] settle_cnt_q, settle_cnt_d;
    logic settled_q, settled_d;
    always_comb begin
        settle_cnt_d = settle_cnt_q;
        settled_d = settled_q;
        if (xtal_off_q) begin
            settle_cnt_d = 32'h0;
            settled_d = 1'b0;
        end else if (settle_cnt_q < 32'(SETTLE_CYCLES)) begin
            settle_cnt_d = settle_cnt_q + 32'h1;
        end else begin
            settled_d = 1'b1; // RL21
        end
    end

    // The active source moves only once the requested oscillator is usable.
    rsclk_src_t src_q, src_d, req_src;
    logic req_ok;
    always_comb begin
        case (src_sel_q)
            2'h0: req_src = RSCLK_SRC_XTAL;
            2'h1: req_src = RSCLK_SRC_RC;
            default: req_src = RSCLK_SRC_SLOW; // RL15
        endcase
        case (req_src)
            RSCLK_SRC_XTAL: req_ok = settled_q & ~xtal_off_q;
            RSCLK_SRC_RC: req_ok = rc_rdy_q[1];
            RSCLK_SRC_SLOW: req_ok = slow_rdy_q[1];
            default: req_ok = 1'b0;
        endcase
        src_d = src_q;
        if (req_ok) begin
            src_d = req_src; // RL22
        end
    end

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            settle_cnt_q <= 32'h0;
            settled_q <= 1'b0;
            src_q <= RSCLK_SRC_XTAL;
        end else begin
            settle_cnt_q <= settle_cnt_d;
            settled_q <= settled_d;
            src_q <= src_d;
        end
    end

    // Two dividers: index 0 is the radio core, index 1 the RF control unit.
    // A new division is only taken at the end of a whole divided period.
    logic [DIV_CNT_W-1:0] dcnt_q [2], dcnt_d [2];
    logic [1:0] dact_q [2], dact_d [2];
    logic [1:0] tick_q, tick_d;
    logic [1:0] den;
    logic [1:0] dreq [2];
    assign den = {radio_q[RC_RFU_EN_BIT], radio_q[RC_CORE_EN_BIT]}; // RL1 RL5
    assign dreq[0] = radio_q[RC_CORE_DIV_LSB+:2];
    assign dreq[1] = radio_q[RC_RFU_DIV_LSB+:2];

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            dcnt_d[i] = '0;
            dact_d[i] = dreq[i];
            tick_d[i] = 1'b0;
            if (den[i]) begin
                if (dcnt_q[i] == div_last(dact_q[i])) begin
                    dcnt_d[i] = '0; // RL3 RL6 RL22
                    dact_d[i] = dreq[i];
                end else begin
                    dcnt_d[i] = dcnt_q[i] + DIV_CNT_W'(1);
                    dact_d[i] = dact_q[i];
                end
                tick_d[i] = (dcnt_d[i] == '0);
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            dcnt_q[0] <= '0;
            dcnt_q[1] <= '0;
            dact_q[0] <= 2'h0;
            dact_q[1] <= 2'h0;
            tick_q <= 2'h0;
        end else begin
            dcnt_q <= dcnt_d;
            dact_q <= dact_d;
            tick_q <= tick_d;
        end
    end

    // Read data.
    logic [31:0] rdata_q, rdata_d;
    always_comb begin
        rdata_d = rdata_q;
        if (setup && !pwrite_in) begin
            rdata_d = 32'h0;
            if (sel_radio) begin
                rdata_d[7:0] = radio_q;
            end
            if (sel_sys) begin
                rdata_d[SC_ON_XTAL_BIT] = (src_q == RSCLK_SRC_XTAL); // RL8
                rdata_d[SC_ON_RC_BIT] = (src_q == RSCLK_SRC_RC); // RL9
                rdata_d[SC_ON_SLOW_BIT] = (src_q == RSCLK_SRC_SLOW); // RL10
                rdata_d[SC_FLT_BYP_BIT] = flt_byp_q;
                rdata_d[SC_XTAL_OFF_BIT] = xtal_off_q;
                rdata_d[SC_SEL_LSB+:2] = src_sel_q;
            end
            if (sel_pmu) begin
                rdata_d[PM_RET_LSB+:4] = ret_q;
                rdata_d[PM_BOOST_BIT] = boost_q;
                rdata_d[PM_BUCK_BIT] = buck_q;
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            rdata_q <= 32'h0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign prdata_out = rdata_q;
    assign radio_core_clk_tick_out = tick_q[0];
    assign rf_ctrl_unit_clk_tick_out = tick_q[1];
    assign lowpower_radio_timer_rst_out = radio_q[RC_LP_RST_BIT]; // RL2
    assign glitch_filter_bypass_out = flt_byp_q; // RL11
    assign fast_crystal_osc_en_out = ~xtal_off_q; // RL12
    assign fast_crystal_settled_out = settled_q;
    assign sysclk_source_sel_out = src_q;
    assign on_fast_crystal_out = (src_q == RSCLK_SRC_XTAL);
    assign on_fast_rc_osc_out = (src_q == RSCLK_SRC_RC);
    assign on_slow_clock_out = (src_q == RSCLK_SRC_SLOW);
    assign retention_keep_out = ret_q;
    assign dcdc_force_boost_out = boost_q;
    assign dcdc_force_buck_out = buck_q & ~boost_q; // RL19

    // Checks.
    property p_core_off;
        @(posedge clock_in) disable iff (!reset_n_in)
        !radio_q[RC_CORE_EN_BIT] |=> !radio_core_clk_tick_out;
    endproperty
    a_core_off: assert property (p_core_off) else $error("core tick while disabled"); // RL1
    property p_lp_reset;
        @(posedge clock_in) disable iff (!reset_n_in)
        $rose(reset_n_in) |-> lowpower_radio_timer_rst_out;
    endproperty
    a_lp_reset: assert property (p_lp_reset) else $error("timer reset not held after reset"); // RL2
    property p_div8;
        @(posedge clock_in) disable iff (!reset_n_in)
        tick_q[0] && dact_q[0] == 2'h3 && den[0] |=> !tick_q[0] [*7];
    endproperty
    a_div8: assert property (p_div8) else $error("divide by eight spacing wrong"); // RL3 RL22
    property p_rfu_div2;
        @(posedge clock_in) disable iff (!reset_n_in)
        tick_q[1] && dact_q[1] == 2'h1 && den[1] |=> !tick_q[1] ##1 (tick_q[1] || !den[1] || $changed(dact_q[1]));
    endproperty
    a_rfu_div2: assert property (p_rfu_div2) else $error("divide by two spacing wrong"); // RL6
    property p_rfu_off;
        @(posedge clock_in) disable iff (!reset_n_in)
        !den[1] |=> !rf_ctrl_unit_clk_tick_out;
    endproperty
    a_rfu_off: assert property (p_rfu_off) else $error("unit tick while disabled"); // RL5
    property p_onehot;
        @(posedge clock_in) disable iff (!reset_n_in)
        $onehot({on_fast_crystal_out, on_fast_rc_osc_out, on_slow_clock_out});
    endproperty
    a_onehot: assert property (p_onehot) else $error("running status not one-hot"); // RL8 RL9 RL10
    property p_rc_switch;
        @(posedge clock_in) disable iff (!reset_n_in)
        src_sel_q == 2'h1 && rc_rdy_q[1] |=> on_fast_rc_osc_out;
    endproperty
    a_rc_switch: assert property (p_rc_switch) else $error("rc source not taken"); // RL15 RL9

    property p_xtal_stop;
        @(posedge clock_in) disable iff (!reset_n_in)
        wr_en && sel_sys && pstrb_in[0] && pwdata_in[SC_XTAL_OFF_BIT] |=> !fast_crystal_osc_en_out ##1 !fast_crystal_settled_out;
    endproperty
    a_xtal_stop: assert property (p_xtal_stop) else $error("crystal not stopped"); // RL12 RL21

    property p_settle_time;
        @(posedge clock_in) disable iff (!reset_n_in)
        $rose(settled_q) |-> $past(settle_cnt_q) == 32'(SETTLE_CYCLES);
    endproperty
    a_settle_time: assert property (p_settle_time) else $error("settled too early"); // RL21

    property p_force_lock;
        @(posedge clock_in) disable iff (!reset_n_in)
        force_lock_q |=> $stable(boost_q) && $stable(buck_q);
    endproperty
    a_force_lock: assert property (p_force_lock) else $error("force bits changed after lock"); // RL20

    property p_boost_wins;
        @(posedge clock_in) disable iff (!reset_n_in)
        boost_q |-> dcdc_force_boost_out && !dcdc_force_buck_out;
    endproperty
    a_boost_wins: assert property (p_boost_wins) else $error("buck forced with boost"); // RL19 RL17

    c_div4: cover property (@(posedge clock_in) disable iff (!reset_n_in) tick_q[0] && dact_q[0] == 2'h2);
    c_to_slow: cover property (@(posedge clock_in) disable iff (!reset_n_in) $rose(on_slow_clock_out));
    c_lock: cover property (@(posedge clock_in) disable iff (!reset_n_in) $rose(force_lock_q));
    c_settled: cover property (@(posedge clock_in) disable iff (!reset_n_in) $rose(settled_q));
endmodule // rsclk_top

// [src/rsclk_pkg.sv]
// Package with register map, field layout, reset values and timing constants of the clock control block.
package rsclk_pkg;
    // Printed offsets are word indices; the byte address is four times the index.
    localparam logic [31:0] RADIO_CLK_IDX = 32'h0500_0008;
    localparam logic [31:0] SYS_CLK_IDX = 32'h0500_000A;
    localparam logic [31:0] PMU_CTRL_IDX = 32'h5000_0010;
    // Only the low index bits are decoded inside the block window.
    localparam int IDX_DEC_W = 5;

    localparam int RC_CORE_EN_BIT = 7;
    localparam int RC_LP_RST_BIT = 6;
    localparam int RC_CORE_DIV_LSB = 4;
    localparam int RC_RFU_EN_BIT = 3;
    localparam int RC_RFU_DIV_LSB = 0;
    localparam logic [7:0] RC_RESET = 8'h40;
    localparam logic [7:0] RC_WMASK = 8'hFB;

    localparam int SC_ON_XTAL_BIT = 7;
    localparam int SC_ON_RC_BIT = 6;
    localparam int SC_ON_SLOW_BIT = 5;
    localparam int SC_FLT_BYP_BIT = 3;
    localparam int SC_XTAL_OFF_BIT = 2;
    localparam int SC_SEL_LSB = 0;
    localparam logic [1:0] SC_SEL_RESET = 2'h0;

    localparam int PM_RET_LSB = 8;
    localparam int PM_BOOST_BIT = 7;
    localparam int PM_BUCK_BIT = 6;
    localparam logic [3:0] PM_RET_RESET = 4'h0;

    typedef enum logic [1:0] {
        RSCLK_SRC_XTAL = 2'b00,
        RSCLK_SRC_RC = 2'b01,
        RSCLK_SRC_SLOW = 2'b10
    } rsclk_src_t;

    localparam int CLK_FREQ_MHZ = 40;
    localparam int XTAL_SETTLE_US = 2000;
    // More than the settle time is needed, so one cycle is added.
    localparam int XTAL_SETTLE_CYCLES = XTAL_SETTLE_US * CLK_FREQ_MHZ + 1;
    localparam int DIV_CNT_W = 3;
endpackage

// [tb/tb_top.sv]
// Self-checking testbench for the radio and system clock control block.
`timescale 1ns/1ps
module tb_top;
    import rsclk_pkg::*;
    localparam int SETTLE = 20;
    localparam logic [31:0] A_RADIO = {25'h0, RADIO_CLK_IDX[4:0], 2'h0};
    localparam logic [31:0] A_SYS = {25'h0, SYS_CLK_IDX[4:0], 2'h0};
    localparam logic [31:0] A_PMU = {25'h0, PMU_CTRL_IDX[4:0], 2'h0};
    logic clock_in, reset_n_in, psel_in, penable_in, pwrite_in;
    logic [31:0] paddr_in, pwdata_in, prdata_out;
    logic [3:0] pstrb_in, retention_keep_out;
    logic pready_out, pslverr_out, fast_rc_osc_ready_in, slow_clock_ready_in;
    logic radio_core_clk_tick_out, rf_ctrl_unit_clk_tick_out, lowpower_radio_timer_rst_out;
    logic glitch_filter_bypass_out, fast_crystal_osc_en_out, fast_crystal_settled_out;
    logic [1:0] sysclk_source_sel_out;
    logic on_fast_crystal_out, on_fast_rc_osc_out, on_slow_clock_out, dcdc_force_boost_out, dcdc_force_buck_out;
    int n_fail = 0;
    int check_count = 0;
    int cycles = 0;
    rsclk_top #(.SETTLE_CYCLES(SETTLE)) dut (.clock_in(clock_in), .reset_n_in(reset_n_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
        .pstrb_in(pstrb_in), .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
        .fast_rc_osc_ready_in(fast_rc_osc_ready_in), .slow_clock_ready_in(slow_clock_ready_in),
        .radio_core_clk_tick_out(radio_core_clk_tick_out), .rf_ctrl_unit_clk_tick_out(rf_ctrl_unit_clk_tick_out),
        .lowpower_radio_timer_rst_out(lowpower_radio_timer_rst_out),
        .glitch_filter_bypass_out(glitch_filter_bypass_out), .fast_crystal_osc_en_out(fast_crystal_osc_en_out),
        .fast_crystal_settled_out(fast_crystal_settled_out), .sysclk_source_sel_out(sysclk_source_sel_out),
        .on_fast_crystal_out(on_fast_crystal_out), .on_fast_rc_osc_out(on_fast_rc_osc_out),
        .on_slow_clock_out(on_slow_clock_out), .retention_keep_out(retention_keep_out),
        .dcdc_force_boost_out(dcdc_force_boost_out), .dcdc_force_buck_out(dcdc_force_buck_out));
    initial clock_in = 1'b0;
    always #12.5 clock_in = ~clock_in;
    task give_verdict();
        if (n_fail == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // A hung handshake or wait must not stall the run forever.
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            n_fail = n_fail + 1;
            give_verdict();
        end
    end
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count = check_count + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    // One APB transfer; values are taken at the edge where pready is sampled high.
    task apb(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
             output logic [31:0] rd, output logic err);
        @(posedge clock_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        pstrb_in <= s;
        @(posedge clock_in);
        penable_in <= 1'b1;
        do begin
            @(posedge clock_in);
        end while (pready_out !== 1'b1);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, s, r, e);
    endtask
    task rdc(input string what, input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, 4'h0, r, e);
        chk(what, exp, r);
        chk({what, " error"}, 32'h0, e);
    endtask
    // Registered outputs are looked at mid-cycle, after the launching edge has settled.
    task settle(input int n);
        repeat (n) @(posedge clock_in);
        @(negedge clock_in);
    endtask
    task do_reset();
        @(posedge clock_in);
        reset_n_in <= 1'b0;
        repeat (3) @(posedge clock_in);
        reset_n_in <= 1'b1;
    endtask
    task ticks(input logic [31:0] exp_core, input logic [31:0] exp_rf);
        int nc;
        int nr;
        nc = 0;
        nr = 0;
        repeat (64) begin
            @(negedge clock_in);
            if (radio_core_clk_tick_out === 1'b1) nc = nc + 1;
            if (rf_ctrl_unit_clk_tick_out === 1'b1) nr = nr + 1;
        end
        chk("core ticks", exp_core, 32'(nc));
        chk("unit ticks", exp_rf, 32'(nr));
    endtask
    initial begin
        logic [31:0] r;
        logic e;
        reset_n_in = 1'b0;
        psel_in = 1'b0;
        penable_in = 1'b0;
        pwrite_in = 1'b0;
        paddr_in = 32'h0;
        pwdata_in = 32'h0;
        pstrb_in = 4'h0;
        fast_rc_osc_ready_in = 1'b0;
        slow_clock_ready_in = 1'b0;
        repeat (3) @(posedge clock_in);
        reset_n_in <= 1'b1;
        settle(0);
        chk("timer reset out", 32'h1, lowpower_radio_timer_rst_out);
        chk("crystal running", 32'h1, fast_crystal_osc_en_out);
        rdc("radio reset", A_RADIO, 32'h0000_0040);
        rdc("system reset", A_SYS, 32'h0000_0080);
        rdc("power reset", A_PMU, 32'h0000_0000);
        apb(1'b0, 32'h0000_0004, 32'h0, 4'h0, r, e);
        chk("unmapped error", 32'h1, e);
        chk("unmapped data", 32'h0, r);
        chk("ready", 32'h1, pready_out);
        ticks(32'h0, 32'h0);
        for (int k = 0; k < 4; k++) begin
            wr(A_RADIO, 32'h88 | (k << 4) | k, 4'h1);
            settle(20);
            ticks(32'(64 >> k), 32'(64 >> k));
        end
        // From the 40 MHz block clock, divide by two gives 20 MHz on both clocks.
        wr(A_RADIO, 32'h0000_0099, 4'h1);
        settle(20);
        ticks(32'h20, 32'h20);
        chk("timer reset out", 32'h0, lowpower_radio_timer_rst_out);
        wr(A_RADIO, 32'hFFFF_FFFF, 4'hF);
        rdc("radio all ones", A_RADIO, 32'h0000_00FB);
        wr(A_RADIO, 32'h0000_0000, 4'h2);
        rdc("radio lane", A_RADIO, 32'h0000_00FB);
        wr(A_RADIO, 32'h0000_0040, 4'h1);
        settle(3);
        ticks(32'h0, 32'h0);
        chk("timer reset out", 32'h1, lowpower_radio_timer_rst_out);
        wr(A_SYS, 32'h0000_0008, 4'h1);
        settle(1);
        chk("filter bypass", 32'h1, glitch_filter_bypass_out);
        // Asking for an oscillator that is not ready must leave the crystal in charge.
        wr(A_SYS, 32'h0000_0009, 4'h1);
        settle(6);
        chk("still crystal", 32'h1, on_fast_crystal_out);
        @(posedge clock_in);
        fast_rc_osc_ready_in <= 1'b1;
        settle(6);
        chk("on rc", 32'h1, on_fast_rc_osc_out);
        chk("source", 32'h1, sysclk_source_sel_out);
        rdc("system on rc", A_SYS, 32'h0000_0049);
        // The crystal is stopped while the RC oscillator runs the system and stays off on the slow clock.
        wr(A_SYS, 32'h0000_000D, 4'h1);
        settle(2);
        chk("crystal stopped", 32'h0, fast_crystal_osc_en_out);
        chk("settled off", 32'h0, fast_crystal_settled_out);
        @(posedge clock_in);
        slow_clock_ready_in <= 1'b1;
        for (int c = 2; c < 4; c++) begin
            wr(A_SYS, 32'h0000_000C | c, 4'h1);
            settle(6);
            chk("on slow", 32'h1, on_slow_clock_out);
            rdc("system on slow", A_SYS, 32'h0000_002C | c);
        end
        chk("crystal kept off", 32'h0, fast_crystal_osc_en_out);
        wr(A_SYS, 32'h0000_000B, 4'h1);
        settle(SETTLE - 4);
        chk("settled early", 32'h0, fast_crystal_settled_out);
        settle(8);
        chk("settled", 32'h1, fast_crystal_settled_out);
        chk("crystal running", 32'h1, fast_crystal_osc_en_out);
        // The crystal is selected only once it reports settled.
        wr(A_SYS, 32'h0000_0008, 4'h1);
        settle(6);
        chk("on crystal", 32'h1, on_fast_crystal_out);
        rdc("system on crystal", A_SYS, 32'h0000_0088);
        wr(A_PMU, 32'h0000_0FC0, 4'h3);
        settle(1);
        chk("retention", 32'hF, retention_keep_out);
        chk("boost", 32'h1, dcdc_force_boost_out);
        chk("buck masked", 32'h0, dcdc_force_buck_out);
        wr(A_PMU, 32'h0000_0500, 4'h3);
        rdc("power locked", A_PMU, 32'h0000_05C0);
        settle(0);
        chk("retention", 32'h5, retention_keep_out);
        do_reset();
        wr(A_PMU, 32'h0000_0000, 4'h3);
        wr(A_PMU, 32'h0000_0040, 4'h3);
        settle(1);
        chk("buck", 32'h1, dcdc_force_buck_out);
        wr(A_PMU, 32'h0000_0080, 4'h3);
        settle(1);
        chk("boost locked", 32'h0, dcdc_force_boost_out);
        rdc("power buck", A_PMU, 32'h0000_0040);
        give_verdict();
    end
endmodule // tb_top
